//--- src/dac_link_defines.svh
`ifndef DAC_LINK_DEFINES_SVH
`define DAC_LINK_DEFINES_SVH

// ----------------------------------------
// address and byte layout
// ----------------------------------------
`define ADDR_PREFIX 6'h26
`define HS_CODE_PREFIX 5'h01
`define CODE_WIDTH 10
`define PD_HI_BIT 5
`define PD_LO_BIT 4

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 50
`define LINK_HALF_NS_FS 5000
`define LINK_HALF_NS_HS 250
`define LINK_HALF_CYC_FS ((`LINK_HALF_NS_FS) / (`CLK_PERIOD_NS))
`define LINK_HALF_CYC_HS ((`LINK_HALF_NS_HS) / (`CLK_PERIOD_NS))

// ----------------------------------------
// master control register offsets
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_DATA 12'h004
`define REG_STATUS 12'h008
`define CTRL_GO_BIT 0
`define CTRL_STOP_BIT 1
`define CTRL_HS_BIT 2
`define CTRL_SEL_BIT 3

`endif

//--- src/dac_link_pkg.sv
package dac_link_pkg;
  typedef enum logic [6:0] {
    S_IDLE = 7'b000_0001,
    S_ADDR = 7'b000_0010,
    S_ACK = 7'b000_0100,
    S_DATA = 7'b000_1000,
    S_SKIP = 7'b001_0000,
    S_HSC = 7'b010_0000,
    S_SPARE = 7'b100_0000
  } slave_state_t;

  typedef enum logic [5:0] {
    M_IDLE = 6'b00_0001,
    M_START = 6'b00_0010,
    M_BIT = 6'b00_0100,
    M_STOP = 6'b00_1000,
    M_RSTART = 6'b01_0000,
    M_DONE = 6'b10_0000
  } master_state_t;
endpackage

//--- src/dac_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dac_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  // wired-and with pull-ups
  wire logic scl = !(scl_oe && !scl_o);
  wire logic sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (input scl, input sda, output scl_o, output scl_oe, output sda_m_o,
    output sda_m_oe);
endinterface
`default_nettype wire

//--- src/dac_link_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "dac_link_defines.svh"

module dac_link_slave
  import dac_link_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic DEVICE_SELECT_PIN,
  dac_link_if.slave LINK,
  output logic [`CODE_WIDTH-1:0] DAC_CODE,
  output logic POWERDOWN_MODE_HIGH_BIT,
  output logic POWERDOWN_MODE_LOW_BIT,
  output logic HIGH_SPEED_TRANSFER_MODE,
  output logic UPDATE
);
  // ----------------------------------------
  // synchronisers and conditions
  // ----------------------------------------
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic [1:0] sel_sync_reg;
  logic [1:0] sel_wait_reg;
  logic sel_reg;
  logic sel_taken_reg;
  slave_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic byte_phase_reg;
  logic [7:0] upper_reg;
  logic ack_is_lower_reg;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic byte_end, addr_ok, ack_due, hs_enter, ack_end, load_now;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], LINK.scl};
      sda_sync_reg <= {sda_sync_reg[0], LINK.sda};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  assign scl_rise = scl_sync_reg[1] && !scl_prev_reg; // any listed rate
  assign scl_fall = !scl_sync_reg[1] && scl_prev_reg;
  assign start_seen = scl_sync_reg[1] && scl_prev_reg && sda_prev_reg && !sda_sync_reg[1];
  assign stop_seen = scl_sync_reg[1] && scl_prev_reg && !sda_prev_reg && sda_sync_reg[1];

  // select pin caught once after reset release, like a power-up strap
  // taken only once the two flops hold a real pin sample
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sel_sync_reg <= 2'b00;
      sel_wait_reg <= 2'b00;
      sel_reg <= 1'b0;
      sel_taken_reg <= 1'b0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[0], DEVICE_SELECT_PIN};
      sel_wait_reg <= {sel_wait_reg[0], 1'b1};
      if (sel_wait_reg[1] && !sel_taken_reg) begin
        sel_reg <= sel_sync_reg[1]; // later pin changes ignored
        sel_taken_reg <= 1'b1;
      end
    end
  end

  function automatic logic addr_match(input logic [7:0] b, input logic s);
    addr_match = (b == {`ADDR_PREFIX, s, 1'b0});
  endfunction

  // ----------------------------------------
  // byte decode
  // ----------------------------------------
  // bits counted on scl rises, so the fall that closes a start
  // condition cannot be mistaken for a data bit
  assign byte_end = scl_fall && (bit_cnt_reg == 4'h8)
    && (state_reg == S_ADDR || state_reg == S_DATA);
  assign addr_ok = addr_match(shift_reg, sel_reg);
  assign ack_due = byte_end && (state_reg == S_DATA || addr_ok);
  assign hs_enter = byte_end && (state_reg == S_ADDR) && !addr_ok
    && (shift_reg[7:3] == `HS_CODE_PREFIX);
  assign ack_end = scl_fall && (state_reg == S_ACK);
  assign load_now = ack_end && ack_is_lower_reg;

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= S_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else if (stop_seen) begin
      state_reg <= S_IDLE;
    end else if (start_seen) begin
      state_reg <= S_ADDR; // repeated start too
      bit_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        S_ADDR, S_DATA: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (ack_due) begin
            state_reg <= S_ACK;
          end else if (hs_enter) begin
            state_reg <= S_HSC; // no acknowledge
          end else if (byte_end) begin
            state_reg <= S_SKIP;
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            state_reg <= S_DATA;
            bit_cnt_reg <= 4'h0;
          end
        end
        S_HSC, S_SKIP, S_IDLE: begin
          state_reg <= state_reg; // deaf until next start
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // byte pairing
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      byte_phase_reg <= 1'b0;
      upper_reg <= 8'h00;
      ack_is_lower_reg <= 1'b0;
    end else if (start_seen) begin
      byte_phase_reg <= 1'b0;
    end else if (ack_due) begin
      if (state_reg == S_ADDR) begin
        ack_is_lower_reg <= 1'b0;
      end else begin
        ack_is_lower_reg <= byte_phase_reg;
        if (!byte_phase_reg) begin
          upper_reg <= shift_reg;
        end
        byte_phase_reg <= !byte_phase_reg; // pairs repeat without readdressing
      end
    end
  end

  // ----------------------------------------
  // acknowledge drive
  // ----------------------------------------
  // released on the ninth fall, before the master's next data change
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      LINK.sda_s_o <= 1'b0; // only ever pulls low
      LINK.sda_s_oe <= 1'b0;
    end else if (stop_seen || start_seen || ack_end) begin
      LINK.sda_s_oe <= 1'b0;
    end else if (ack_due) begin
      LINK.sda_s_oe <= 1'b1;
    end
  end

  // ----------------------------------------
  // converter register
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      DAC_CODE <= '0;
      POWERDOWN_MODE_HIGH_BIT <= 1'b0;
      POWERDOWN_MODE_LOW_BIT <= 1'b0;
      UPDATE <= 1'b0;
    end else begin
      UPDATE <= load_now;
      if (load_now) begin
        DAC_CODE <= {upper_reg[3:0], shift_reg[7:2]};
        POWERDOWN_MODE_HIGH_BIT <= upper_reg[`PD_HI_BIT];
        POWERDOWN_MODE_LOW_BIT <= upper_reg[`PD_LO_BIT];
      end
    end
  end

  // ----------------------------------------
  // speed setting
  // ----------------------------------------
  // only a stop leaves high speed; restarts keep it
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      HIGH_SPEED_TRANSFER_MODE <= 1'b0;
    end else if (stop_seen) begin
      HIGH_SPEED_TRANSFER_MODE <= 1'b0;
    end else if (hs_enter) begin
      HIGH_SPEED_TRANSFER_MODE <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- src/dac_link_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "dac_link_defines.svh"

module dac_link_master
  import dac_link_pkg::*;
#(
  parameter int HALF_FS = `LINK_HALF_CYC_FS,
  parameter int HALF_HS = `LINK_HALF_CYC_HS
)(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  dac_link_if.master LINK
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  master_state_t state_reg;
  logic [15:0] data_reg;
  logic hs_reg, stop_reg, sel_reg, busy_reg, nack_reg, hs_done_reg;
  logic [1:0] sda_sync_reg;
  logic [15:0] div_reg;
  logic [1:0] phase_reg;
  logic [4:0] bit_idx_reg;
  logic [26:0] frame_reg;
  logic tick;
  logic acc;

  assign acc = PSEL && PENABLE;
  assign tick = (div_reg == 16'h0000);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= acc && !PREADY;
      PSLVERR <= acc && !PREADY && PADDR != `REG_CTRL && PADDR != `REG_DATA
        && PADDR != `REG_STATUS;
      case (PADDR)
        `REG_CTRL: PRDATA <= {28'h000_0000, sel_reg, hs_reg, stop_reg, busy_reg};
        `REG_DATA: PRDATA <= {16'h0000, data_reg};
        `REG_STATUS: PRDATA <= {30'h0000_0000, nack_reg, busy_reg};
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // bit engine: four phases per bit
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sda_sync_reg <= 2'b11;
      div_reg <= 16'h0000;
      state_reg <= M_IDLE;
      data_reg <= 16'h0000;
      hs_reg <= 1'b0;
      stop_reg <= 1'b1;
      sel_reg <= 1'b0;
      busy_reg <= 1'b0;
      nack_reg <= 1'b0;
      hs_done_reg <= 1'b0;
      phase_reg <= 2'd0;
      bit_idx_reg <= 5'd0;
      frame_reg <= '0;
      LINK.scl_o <= 1'b0;
      LINK.scl_oe <= 1'b0;
      LINK.sda_m_o <= 1'b0;
      LINK.sda_m_oe <= 1'b0;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], LINK.sda};
      div_reg <= tick ? 16'((hs_reg && hs_done_reg) ? HALF_HS / 2 : HALF_FS / 2)
        : div_reg - 16'h0001;
      // write lands at the edge where the ready cycle is sampled
      if (acc && PREADY && PWRITE && !busy_reg) begin
        if (PADDR == `REG_DATA) data_reg <= PWDATA[15:0];
        if (PADDR == `REG_CTRL) begin
          stop_reg <= PWDATA[`CTRL_STOP_BIT];
          hs_reg <= PWDATA[`CTRL_HS_BIT];
          sel_reg <= PWDATA[`CTRL_SEL_BIT];
          if (PWDATA[`CTRL_GO_BIT]) begin
            busy_reg <= 1'b1;
            nack_reg <= 1'b0;
            state_reg <= M_START;
            phase_reg <= 2'd0;
          end
        end
      end else if (tick) begin
        case (state_reg)
          M_START, M_RSTART: begin
            phase_reg <= phase_reg + 2'd1;
            case (phase_reg)
              2'd0: begin LINK.sda_m_oe <= 1'b0; LINK.scl_oe <= 1'b0; end
              2'd1: LINK.sda_m_oe <= 1'b1;
              2'd2: LINK.scl_oe <= 1'b1;
              default: begin
                state_reg <= M_BIT;
                bit_idx_reg <= 5'd0;
                if (hs_reg && !hs_done_reg && state_reg == M_START) begin
                  frame_reg <= {8'h08, 1'b1, 18'h0_0000};
                end else begin
                  frame_reg <= {`ADDR_PREFIX, sel_reg, 1'b0, 1'b1, data_reg[15:8], 1'b1,
                    data_reg[7:0], 1'b1};
                  hs_done_reg <= hs_reg;
                end
              end
            endcase
          end
          M_BIT: begin
            phase_reg <= phase_reg + 2'd1;
            case (phase_reg)
              2'd0: LINK.sda_m_oe <= !frame_reg[26]; // change while low
              2'd1: LINK.scl_oe <= 1'b0;
              2'd2: if (bit_idx_reg == 5'd8 || bit_idx_reg == 5'd17 || bit_idx_reg == 5'd26)
                if (sda_sync_reg[1] && !(hs_reg && !hs_done_reg)) nack_reg <= 1'b1;
              default: begin
                LINK.scl_oe <= 1'b1;
                frame_reg <= {frame_reg[25:0], 1'b0};
                bit_idx_reg <= bit_idx_reg + 5'd1;
                if (hs_reg && !hs_done_reg && bit_idx_reg == 5'd8) begin
                  state_reg <= M_RSTART;
                  hs_done_reg <= 1'b1;
                end else if (bit_idx_reg == 5'd26) begin
                  state_reg <= stop_reg ? M_STOP : M_DONE;
                end
              end
            endcase
          end
          M_STOP: begin
            phase_reg <= phase_reg + 2'd1;
            case (phase_reg)
              2'd0: LINK.sda_m_oe <= 1'b1;
              2'd1: LINK.scl_oe <= 1'b0;
              2'd2: LINK.sda_m_oe <= 1'b0;
              default: begin state_reg <= M_IDLE; busy_reg <= 1'b0; hs_done_reg <= 1'b0; end
            endcase
          end
          M_DONE: begin
            LINK.sda_m_oe <= 1'b0;
            state_reg <= M_IDLE;
            busy_reg <= 1'b0;
          end
          M_IDLE: phase_reg <= 2'd0;
          default: state_reg <= M_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/dac_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dac_link_asserts (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic UPDATE,
  input wire logic HIGH_SPEED_TRANSFER_MODE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // ----
  // bus events
  // ----
  sequence start_cond;
    scl && $fell(sda);
  endsequence
  sequence stop_cond;
    scl && $rose(sda);
  endsequence
  sequence ack_begin;
    $rose(sda_s_oe);
  endsequence
  // ----
  // checks
  // ----
  AST_OD_LOW: assert property (sda_s_o == 1'b0)
    else $error("slave data output not low");
  AST_PULL: assert property (sda_s_oe |-> !sda)
    else $error("enabled slave does not pull line low");
  AST_START_QUIET: assert property (start_cond |-> !sda_s_oe [*8])
    else $error("slave drives right after start");
  AST_ACK_SCL_LOW: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave data changed while clock high");
  AST_ACK_HOLD: assert property (ack_begin |-> sda_s_oe [*8])
    else $error("acknowledge too short");
  AST_ACK_BOUND: assert property (ack_begin |-> ##[1:200] !sda_s_oe)
    else $error("acknowledge never released");
  AST_UPD_PULSE: assert property (UPDATE |=> !UPDATE)
    else $error("update wider than one cycle");
  AST_UPD_AFTER_ACK: assert property (UPDATE |-> !scl && !sda_s_oe)
    else $error("update outside acknowledge fall");
  AST_HS_STOP: assert property (stop_cond |-> ##[1:8] !HIGH_SPEED_TRANSFER_MODE)
    else $error("high speed kept after stop");
  AST_HS_NOACK: assert property ($rose(HIGH_SPEED_TRANSFER_MODE) |-> !sda_s_oe [*8])
    else $error("master code acknowledged");
endmodule
`default_nettype wire

//--- bench/dac_i2c_slave_interface_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "dac_link_defines.svh"
module dac_i2c_slave_interface_test
  import dac_link_pkg::*;
;
  logic clk, rst_b, sel_pin, psel, penable, pwrite, pready, pslverr, upd, high_speed_transfer_mode, pd_hi, pd_lo;
  logic hs_now;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [9:0] code;
  logic [12:0] exp_q[$];
  logic [8:0] bits, first9;
  int nbit, mismatches, checked;
  dac_link_if link();
  dac_link_master #(.HALF_FS(20), .HALF_HS(8)) dac_link_master_i (.CLK(clk), .RST_B(rst_b),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  dac_link_slave dac_link_slave_i (.CLK(clk), .RST_B(rst_b), .DEVICE_SELECT_PIN(sel_pin),
    .LINK(link), .DAC_CODE(code), .POWERDOWN_MODE_HIGH_BIT(pd_hi),
    .POWERDOWN_MODE_LOW_BIT(pd_lo), .HIGH_SPEED_TRANSFER_MODE(high_speed_transfer_mode), .UPDATE(upd));
  dac_link_asserts dac_link_asserts_i (.CLK(clk), .RST_B(rst_b), .scl(link.scl),
    .sda(link.sda), .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe), .UPDATE(upd),
    .HIGH_SPEED_TRANSFER_MODE(high_speed_transfer_mode));
  always #25 clk = ~clk;
  // ----
  // checking
  // ----
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // wire view: first byte and acknowledge after the latest start
  always @(negedge link.sda) if (link.scl === 1'b1) nbit = 0;
  always @(posedge link.scl) begin
    bits = {bits[7:0], link.sda};
    nbit++;
    if (nbit == 9) first9 = bits;
  end
  always @(posedge clk) begin
    if (upd === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "update not expected");
      else chk({high_speed_transfer_mode, pd_hi, pd_lo, code} === exp_q.pop_front(), "update contents");
    end
  end
  // ----
  // bus master
  // ----
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    chk(n == 2, "ready latency");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one update: bytes built here, not by the design's helpers
  task automatic frame(input logic [9:0] c, input logic [1:0] pd, input logic hs,
      input logic stp, input logic sb);
    logic e;
    int n;
    apb(1'b1, `REG_DATA, {16'h0000, 2'b00, pd, c[9:6], c[5:0], 2'($urandom)}, e);
    apb(1'b1, `REG_CTRL, {28'h000_0000, sb, hs, stp, 1'b1}, e);
    hs_now = hs_now | hs;
    if (sb === sel_pin) exp_q.push_back({hs_now, pd, c});
    repeat (4) @(posedge clk);
    n = 0;
    do begin
      apb(1'b0, `REG_STATUS, 32'h0000_0000, e);
      n++;
    end while (r[0] !== 1'b0);
    chk(n < 3000, "busy stuck");
    chk(r[1] === (sb !== sel_pin), "nack flag");
    chk(first9 === {6'h26, sb, 1'b0, sb !== sel_pin}, "address and ack on wire");
    if (stp) begin
      hs_now = 1'b0;
      repeat (10) @(posedge clk);
      chk(link.scl === 1'b1 && link.sda === 1'b1 && high_speed_transfer_mode === 1'b0, "idle after stop");
    end
  endtask
  task automatic test_end(input string name);
    chk(exp_q.size() == 0, "update missing");
    $display("test %s done", name);
  endtask
  task automatic do_reset(input logic pin);
    rst_b <= 1'b0;
    sel_pin <= pin;
    hs_now = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    logic e;
    {clk, rst_b, sel_pin, psel, penable, pwrite, paddr, pwdata, nbit, bits} = '0;
    {hs_now, mismatches, checked} = '0;
    void'($urandom(21930));
    do_reset(1'b0);
    chk({code, pd_hi, pd_lo, high_speed_transfer_mode} === 13'h0000, "reset outputs");
    apb(1'b0, `REG_STATUS, 32'h0000_0000, e);
    chk(r === 32'h0000_0000 && e === 1'b0, "status reset");
    apb(1'b0, 12'h00C, 32'h0000_0000, e);
    chk(e === 1'b1, "unmapped address");
    test_end("reset");
    for (int i = 0; i < 4; i++) frame(i[0] ? 10'h3FF : 10'h000, i[1:0], 1'b0, i == 3, 1'b0);
    test_end("codes");
    frame(10'($urandom), 2'($urandom), 1'b0, 1'b1, 1'b1);
    frame(10'($urandom), 2'($urandom), 1'b0, 1'b1, 1'b0);
    test_end("select");
    do_reset(1'b1);
    chk(code === 10'h000, "code cleared");
    frame(10'($urandom), 2'($urandom), 1'b1, 1'b0, 1'b1);
    frame(10'($urandom), 2'($urandom), 1'b0, 1'b1, 1'b1);
    frame(10'($urandom), 2'($urandom), 1'b0, 1'b1, 1'b1);
    test_end("high speed");
    wrap_up;
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    wrap_up;
  end
endmodule
`default_nettype wire
